// ---- inc/insn_decoder_map.vh ----
// Purpose: constants for the 14-bit instruction decoder
// Assumes: included by bare name from every design file except the cycle counter
// Notes:   definitions only
`ifndef INSN_DECODER_MAP_VH
`define INSN_DECODER_MAP_VH

// Field positions inside the instruction word
`define INSN_W        14
`define PFX_HI        13
`define PFX_LO        12
`define SUB_HI        11
`define SUB_LO        8
`define DEST_BIT      7
`define FADDR_HI      6
`define BIDX_HI       9
`define BIDX_LO       7
`define BSUB_HI       11
`define BSUB_LO       10

// Prefix values
`define PFX_BYTE      2'h0
`define PFX_BIT       2'h1
`define PFX_LIT       2'h3

// Byte-oriented sub codes under the byte prefix
`define SB_STORE      4'h0
`define SB_CLEAR      4'h1
`define SB_SUB        4'h2
`define SB_DEC        4'h3
`define SB_OR         4'h4
`define SB_AND        4'h5
`define SB_XOR        4'h6
`define SB_ADD        4'h7
`define SB_MOVE       4'h8
`define SB_COMP       4'h9
`define SB_INC        4'hA
`define SB_DECSKIP    4'hB
`define SB_RRC        4'hC
`define SB_RLC        4'hD
`define SB_SWAP       4'hE
`define SB_INCSKIP    4'hF

// Sub codes under the literal prefix
`define SL_LOADW      4'h0
`define SL_PCLATCH    4'h1
`define SL_LSL        4'h5
`define SL_LSR        4'h6
`define SL_ASR        4'h7
`define SL_OR         4'h8
`define SL_AND        4'h9
`define SL_XOR        4'hA
`define SL_SUBB       4'hB
`define SL_LSUB       4'hC
`define SL_ADDC       4'hD
`define SL_ADD        4'hE

// Bit-operation sub codes
`define BS_CLR        2'h0
`define BS_SET        2'h1
`define BS_TSTC       2'h2
`define BS_TSTS       2'h3

// Special markers in the low byte
`define BANK_MARK     3'h1
`define CLEAR_WORKING_ZERO     6'h00

// Indirect data register addresses and the one-cycle extra cost
`define INDIRECT0_ADDR 7'h00
`define INDIRECT1_ADDR 7'h01
`define CYC_EXTRA      2'h1

// Operation identifiers
`define OP_ADD_WREG_FILE   6'h00
`define OP_ADD_CARRY       6'h01
`define OP_AND_WREG_FILE   6'h02
`define OP_ASR_FILE        6'h03
`define OP_LSL_FILE        6'h04
`define OP_LSR_FILE        6'h05
`define OP_CLEAR_FILE      6'h06
`define OP_CLEAR_WORKING   6'h07
`define OP_COMPLEMENT      6'h08
`define OP_DECREMENT       6'h09
`define OP_INCREMENT       6'h0A
`define OP_OR_WREG_FILE    6'h0B
`define OP_MOVE_FILE       6'h0C
`define OP_STORE_WORKING   6'h0D
`define OP_ROTATE_LEFT     6'h0E
`define OP_ROTATE_RIGHT    6'h0F
`define OP_SUB_WREG        6'h10
`define OP_SUB_BORROW      6'h11
`define OP_NIBBLE_SWAP     6'h12
`define OP_XOR_WREG_FILE   6'h13
`define OP_DEC_SKIP_ZERO   6'h14
`define OP_INC_SKIP_ZERO   6'h15
`define OP_BIT_CLEAR       6'h16
`define OP_BIT_SET         6'h17
`define OP_BIT_SKIP_CLEAR  6'h18
`define OP_BIT_SKIP_SET    6'h19
`define OP_ADD_LITERAL     6'h1A
`define OP_AND_LITERAL     6'h1B
`define OP_OR_LITERAL      6'h1C
`define OP_LOAD_BANK       6'h1D
`define OP_LOAD_PC_HIGH    6'h1E
`define OP_LOAD_WORKING    6'h1F
`define OP_LIT_MINUS_W     6'h20
`define OP_XOR_LITERAL     6'h21
`define OP_ILLEGAL         6'h3F

`endif

// ---- hdl/flag_effects.v ----
// Purpose: status flags touched by each operation
// Assumes: operation identifiers from the map header
// Notes:   purely combinational
`timescale 1ns/1ps
`include "insn_decoder_map.vh"

module flag_effects (
  input  wire [5:0] op,
  output reg        upd_c,
  output reg        upd_dc,
  output reg        upd_z,
  output reg        carry_in
);
  always @* begin
    upd_c    = 1'b0;
    upd_dc   = 1'b0;
    upd_z    = 1'b0;
    carry_in = 1'b0;
    case (op)
      `OP_ADD_WREG_FILE, `OP_SUB_WREG, `OP_ADD_LITERAL, `OP_LIT_MINUS_W: begin
        upd_c  = 1'b1; // [RQ2] [RQ3] [RQ9]
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      `OP_ADD_CARRY, `OP_SUB_BORROW: begin
        upd_c    = 1'b1; // [RQ2] [RQ3]
        upd_dc   = 1'b1;
        upd_z    = 1'b1;
        carry_in = 1'b1;
      end
      `OP_AND_WREG_FILE, `OP_OR_WREG_FILE, `OP_XOR_WREG_FILE,
      `OP_AND_LITERAL, `OP_OR_LITERAL, `OP_XOR_LITERAL: begin
        upd_z = 1'b1; // [RQ4] [RQ10]
      end
      `OP_ASR_FILE, `OP_LSL_FILE, `OP_LSR_FILE: begin
        upd_c = 1'b1; // [RQ5]
        upd_z = 1'b1;
      end
      `OP_ROTATE_LEFT, `OP_ROTATE_RIGHT: begin
        upd_c    = 1'b1; // [RQ6]
        carry_in = 1'b1;
      end
      `OP_CLEAR_FILE, `OP_CLEAR_WORKING, `OP_COMPLEMENT, `OP_DECREMENT,
      `OP_INCREMENT, `OP_MOVE_FILE: begin
        upd_z = 1'b1; // [RQ14]
      end
      default: begin
        upd_z = 1'b0; // Skips, bit ops, loads and swap touch no flag [RQ7]
      end
    endcase
  end
endmodule

// ---- hdl/cycle_counter.v ----
// Purpose: counts the no-operation cycles that follow an instruction
// Assumes: load only while the count is zero
// Notes:   frozen while ce is low
`timescale 1ns/1ps

module cycle_counter (
  input  wire       clk,
  input  wire       srst,
  input  wire       ce,
  input  wire       load,
  input  wire [1:0] extra,
  output reg  [1:0] rem_r,
  output reg  [1:0] rem_nxt
);
  always @* begin
    rem_nxt = rem_r;
    if (load) begin
      rem_nxt = extra;
    end else if (rem_r != 2'h0) begin
      rem_nxt = rem_r - 2'h1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rem_r <= 2'h0;
    end else if (ce) begin
      rem_r <= rem_nxt;
    end
  end
endmodule

// ---- hdl/enhanced_insn_decoder.v ----
// Purpose: decodes 14-bit core instructions into control for the datapath
// Assumes: datapath presents result_zero, tested_bit and the select MSbs
//          in the cycle the instruction is offered
// Notes:   one instruction in flight; extra cycles show as nop_cycle
// Operation
// [RQ1] Instructions are 14 bits; file ops hold opcode, destination, 7-bit address.
// [RQ2] Add is 00 0111, add-with-carry 11 1101; both set C, DC, Z.
// [RQ3] Subtract is 00 0010, with borrow 11 1011; both set C, DC, Z.
// [RQ4] AND, OR, XOR with file are 00 0101/0100/0110, zero flag only.
// [RQ5] Arith right, left, right shifts are 11 0111/0101/0110, set C and Z.
// [RQ6] Rotate left/right through carry are 00 1101/1100, carry flag only.
// [RQ7] Dec/inc skip-if-zero take two cycles on zero, touch no flags.
// [RQ8] Bit ops: prefix 01, sub-code, bit index, address; clear, set, skip tests.
// [RQ9] Add literal and literal minus working write working, set C, DC, Z.
// [RQ10] AND, OR, XOR literal are 11 1001/1000/1010, zero flag only.
// [RQ11] Load PC latch 7 bits, bank select 5 bits, working 8 bits.
// [RQ12] PC change or true test costs two cycles, second a no-op.
// [RQ13] Indirect access with select MSb set adds one cycle.
// [RQ14] Also clear, clear working, store, complement, dec, inc, move, swap.
`timescale 1ns/1ps
`include "insn_decoder_map.vh"

module enhanced_insn_decoder (
  input  wire                 clk,
  input  wire                 srst,
  input  wire                 ce,
  input  wire                 insn_valid,
  input  wire [`INSN_W-1:0]   insn,
  input  wire                 result_zero,
  input  wire                 tested_bit,
  input  wire                 fsr0_msb,
  input  wire                 fsr1_msb,
  output reg                  insn_ready,
  output reg                  dec_valid,
  output reg  [5:0]           op_id,
  output reg                  illegal,
  output reg                  dest_file,
  output reg  [6:0]           file_addr,
  output reg  [2:0]           bit_idx,
  output reg  [7:0]           literal,
  output reg                  wr_working,
  output reg                  wr_file,
  output reg                  wr_bank_select,
  output reg                  wr_pc_high_latch,
  output reg                  upd_carry,
  output reg                  upd_digit_carry,
  output reg                  upd_zero,
  output reg                  carry_in_used,
  output reg                  skip_next,
  output reg                  indirect_extra,
  output reg  [1:0]           cycles,
  output reg                  nop_cycle
);

  wire [1:0] pfx   = insn[`PFX_HI:`PFX_LO];
  wire [3:0] sub   = insn[`SUB_HI:`SUB_LO];
  wire [1:0] bsub  = insn[`BSUB_HI:`BSUB_LO];
  wire       d_bit = insn[`DEST_BIT];
  wire [6:0] faddr = insn[`FADDR_HI:0];

  reg  [5:0] op_nxt;
  reg        file_op_nxt;
  reg        dest_nxt;
  reg  [7:0] lit_nxt;
  reg        wr_w_nxt;
  reg        wr_f_nxt;
  reg        wr_bsr_nxt;
  reg        wr_pcl_nxt;
  reg        skip_nxt;
  reg        ind_nxt;
  reg  [1:0] extra_nxt;

  wire       f_c;
  wire       f_dc;
  wire       f_z;
  wire       f_cin;
  wire [1:0] rem_r;
  wire [1:0] rem_nxt;

  wire accept = insn_valid && insn_ready;

  // Operation classification
  always @* begin
    op_nxt      = `OP_ILLEGAL;
    file_op_nxt = 1'b0;
    case (pfx)
      `PFX_BYTE: begin
        file_op_nxt = 1'b1; // [RQ1]
        case (sub)
          `SB_STORE: begin
            if (d_bit) begin
              op_nxt = `OP_STORE_WORKING; // [RQ14]
            end else if (insn[7:5] == `BANK_MARK) begin
              op_nxt      = `OP_LOAD_BANK; // [RQ11]
              file_op_nxt = 1'b0;
            end else begin
              file_op_nxt = 1'b0;
            end
          end
          `SB_CLEAR: begin
            if (d_bit) begin
              op_nxt = `OP_CLEAR_FILE; // [RQ14]
            end else if (insn[7:2] == `CLEAR_WORKING_ZERO) begin
              op_nxt      = `OP_CLEAR_WORKING;
              file_op_nxt = 1'b0;
            end else begin
              file_op_nxt = 1'b0;
            end
          end
          `SB_SUB:     op_nxt = `OP_SUB_WREG; // [RQ3]
          `SB_DEC:     op_nxt = `OP_DECREMENT; // [RQ14]
          `SB_OR:      op_nxt = `OP_OR_WREG_FILE; // [RQ4]
          `SB_AND:     op_nxt = `OP_AND_WREG_FILE; // [RQ4]
          `SB_XOR:     op_nxt = `OP_XOR_WREG_FILE; // [RQ4]
          `SB_ADD:     op_nxt = `OP_ADD_WREG_FILE; // [RQ2]
          `SB_MOVE:    op_nxt = `OP_MOVE_FILE; // [RQ14]
          `SB_COMP:    op_nxt = `OP_COMPLEMENT; // [RQ14]
          `SB_INC:     op_nxt = `OP_INCREMENT; // [RQ14]
          `SB_DECSKIP: op_nxt = `OP_DEC_SKIP_ZERO; // [RQ7]
          `SB_RRC:     op_nxt = `OP_ROTATE_RIGHT; // [RQ6]
          `SB_RLC:     op_nxt = `OP_ROTATE_LEFT; // [RQ6]
          `SB_SWAP:    op_nxt = `OP_NIBBLE_SWAP; // [RQ14]
          `SB_INCSKIP: op_nxt = `OP_INC_SKIP_ZERO; // [RQ7]
          default:     op_nxt = `OP_ILLEGAL;
        endcase
      end
      `PFX_BIT: begin
        file_op_nxt = 1'b1; // [RQ8]
        case (bsub)
          `BS_CLR:  op_nxt = `OP_BIT_CLEAR;
          `BS_SET:  op_nxt = `OP_BIT_SET;
          `BS_TSTC: op_nxt = `OP_BIT_SKIP_CLEAR;
          `BS_TSTS: op_nxt = `OP_BIT_SKIP_SET;
          default:  op_nxt = `OP_ILLEGAL;
        endcase
      end
      `PFX_LIT: begin
        case (sub)
          `SL_LOADW: op_nxt = `OP_LOAD_WORKING; // [RQ11]
          `SL_PCLATCH: begin
            if (d_bit) begin
              op_nxt = `OP_LOAD_PC_HIGH; // [RQ11]
            end
          end
          `SL_LSL: begin
            op_nxt      = `OP_LSL_FILE; // [RQ5]
            file_op_nxt = 1'b1;
          end
          `SL_LSR: begin
            op_nxt      = `OP_LSR_FILE; // [RQ5]
            file_op_nxt = 1'b1;
          end
          `SL_ASR: begin
            op_nxt      = `OP_ASR_FILE; // [RQ5]
            file_op_nxt = 1'b1;
          end
          `SL_OR:    op_nxt = `OP_OR_LITERAL; // [RQ10]
          `SL_AND:   op_nxt = `OP_AND_LITERAL; // [RQ10]
          `SL_XOR:   op_nxt = `OP_XOR_LITERAL; // [RQ10]
          `SL_SUBB: begin
            op_nxt      = `OP_SUB_BORROW; // [RQ3]
            file_op_nxt = 1'b1;
          end
          `SL_LSUB:  op_nxt = `OP_LIT_MINUS_W; // [RQ9]
          `SL_ADDC: begin
            op_nxt      = `OP_ADD_CARRY; // [RQ2]
            file_op_nxt = 1'b1;
          end
          `SL_ADD:   op_nxt = `OP_ADD_LITERAL; // [RQ9]
          default:   op_nxt = `OP_ILLEGAL;
        endcase
      end
      default: begin
        op_nxt = `OP_ILLEGAL; // Prefix 10 carries no listed operation
      end
    endcase
    if (op_nxt == `OP_ILLEGAL) begin
      file_op_nxt = 1'b0;
    end
  end

  // Destination, literal, write enables and skip condition
  always @* begin
    dest_nxt   = 1'b0;
    lit_nxt    = 8'h00;
    wr_w_nxt   = 1'b0;
    wr_f_nxt   = 1'b0;
    wr_bsr_nxt = 1'b0;
    wr_pcl_nxt = 1'b0;
    skip_nxt   = 1'b0;
    case (op_nxt)
      `OP_STORE_WORKING, `OP_CLEAR_FILE, `OP_BIT_CLEAR, `OP_BIT_SET: begin
        dest_nxt = 1'b1; // [RQ8] [RQ14]
        wr_f_nxt = 1'b1;
      end
      `OP_CLEAR_WORKING: begin
        wr_w_nxt = 1'b1; // [RQ14]
      end
      `OP_BIT_SKIP_CLEAR: begin
        skip_nxt = ~tested_bit; // [RQ8]
      end
      `OP_BIT_SKIP_SET: begin
        skip_nxt = tested_bit; // [RQ8]
      end
      `OP_LOAD_BANK: begin
        lit_nxt    = {3'h0, insn[4:0]}; // [RQ11]
        wr_bsr_nxt = 1'b1;
      end
      `OP_LOAD_PC_HIGH: begin
        lit_nxt    = {1'b0, insn[6:0]}; // [RQ11]
        wr_pcl_nxt = 1'b1;
      end
      `OP_LOAD_WORKING, `OP_ADD_LITERAL, `OP_LIT_MINUS_W, `OP_AND_LITERAL,
      `OP_OR_LITERAL, `OP_XOR_LITERAL: begin
        lit_nxt  = insn[7:0]; // [RQ9] [RQ10] [RQ11]
        wr_w_nxt = 1'b1;
      end
      `OP_ILLEGAL: begin
        dest_nxt = 1'b0;
      end
      default: begin
        // Byte ops: d picks file (1) or working (0)
        dest_nxt = d_bit; // [RQ1]
        wr_f_nxt = d_bit;
        wr_w_nxt = ~d_bit;
        if (op_nxt == `OP_DEC_SKIP_ZERO || op_nxt == `OP_INC_SKIP_ZERO) begin
          skip_nxt = result_zero; // [RQ7]
        end
      end
    endcase
  end

  // Indirect target only costs when its select MSb is set
  always @* begin
    ind_nxt = 1'b0;
    if (file_op_nxt) begin
      if (faddr == `INDIRECT0_ADDR) begin
        ind_nxt = fsr0_msb; // [RQ13]
      end else if (faddr == `INDIRECT1_ADDR) begin
        ind_nxt = fsr1_msb; // [RQ13]
      end
    end
    extra_nxt = (skip_nxt ? `CYC_EXTRA : 2'h0) + (ind_nxt ? `CYC_EXTRA : 2'h0); // [RQ12]
  end

  flag_effects u_flags (
    .op       (op_nxt),
    .upd_c    (f_c),
    .upd_dc   (f_dc),
    .upd_z    (f_z),
    .carry_in (f_cin)
  );

  cycle_counter u_cycles (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .load    (accept),
    .extra   (extra_nxt),
    .rem_r   (rem_r),
    .rem_nxt (rem_nxt)
  );

  // Control outputs; the no-op cycles block the next fetch
  always @(posedge clk) begin
    if (srst) begin
      insn_ready <= 1'b0;
      dec_valid  <= 1'b0;
      nop_cycle  <= 1'b0;
    end else if (ce) begin
      insn_ready <= (rem_nxt == 2'h0);
      dec_valid  <= accept;
      nop_cycle  <= !accept && (rem_r != 2'h0); // [RQ12] [RQ13]
    end
  end

  // Decoded fields held until the next accepted instruction
  always @(posedge clk) begin
    if (srst) begin
      op_id            <= `OP_ILLEGAL;
      illegal          <= 1'b0;
      dest_file        <= 1'b0;
      file_addr        <= 7'h00;
      bit_idx          <= 3'h0;
      literal          <= 8'h00;
      wr_working       <= 1'b0;
      wr_file          <= 1'b0;
      wr_bank_select   <= 1'b0;
      wr_pc_high_latch <= 1'b0;
      upd_carry        <= 1'b0;
      upd_digit_carry  <= 1'b0;
      upd_zero         <= 1'b0;
      carry_in_used    <= 1'b0;
      skip_next        <= 1'b0;
      indirect_extra   <= 1'b0;
      cycles           <= 2'h0;
    end else if (ce && accept) begin
      op_id            <= op_nxt;
      illegal          <= (op_nxt == `OP_ILLEGAL);
      dest_file        <= dest_nxt;
      file_addr        <= file_op_nxt ? faddr : 7'h00; // [RQ1]
      bit_idx          <= (pfx == `PFX_BIT) ? insn[`BIDX_HI:`BIDX_LO] : 3'h0; // [RQ8]
      literal          <= lit_nxt;
      wr_working       <= wr_w_nxt;
      wr_file          <= wr_f_nxt;
      wr_bank_select   <= wr_bsr_nxt;
      wr_pc_high_latch <= wr_pcl_nxt;
      upd_carry        <= f_c;
      upd_digit_carry  <= f_dc;
      upd_zero         <= f_z;
      carry_in_used    <= f_cin;
      skip_next        <= skip_nxt; // [RQ7] [RQ12]
      indirect_extra   <= ind_nxt;
      cycles           <= `CYC_EXTRA + extra_nxt; // [RQ12] [RQ13]
    end
  end

endmodule

// ---- test/insn_decoder_checker_asserts.sv ----
// Purpose: concurrent checks on the instruction decoder ports
// Assumes: ce stays high while an instruction has no-op cycles pending
// Notes:   attached to every decoder instance by bind
`timescale 1ns/1ps
`include "insn_decoder_map.vh"

module insn_decoder_checker (
  input wire              clk,
  input wire              srst,
  input wire              ce,
  input wire              insn_valid,
  input wire [`INSN_W-1:0] insn,
  input wire              result_zero,
  input wire              tested_bit,
  input wire              fsr0_msb,
  input wire              fsr1_msb,
  input wire              insn_ready,
  input wire              dec_valid,
  input wire [5:0]        op_id,
  input wire              illegal,
  input wire              dest_file,
  input wire [6:0]        file_addr,
  input wire [2:0]        bit_idx,
  input wire [7:0]        literal,
  input wire              wr_working,
  input wire              wr_file,
  input wire              wr_bank_select,
  input wire              wr_pc_high_latch,
  input wire              upd_carry,
  input wire              upd_digit_carry,
  input wire              upd_zero,
  input wire              carry_in_used,
  input wire              skip_next,
  input wire              indirect_extra,
  input wire [1:0]        cycles,
  input wire              nop_cycle
);
  wire acc;
  assign acc = ce && insn_valid && insn_ready;

  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_one_nop;
    (dec_valid && !insn_ready) ##1 (insn_ready && nop_cycle && !dec_valid);
  endsequence
  sequence s_two_nop;
    (dec_valid && !insn_ready) ##1 (!insn_ready && nop_cycle) ##1 (insn_ready && nop_cycle);
  endsequence

  chk_pulse_follows: assert property (
    ce |=> dec_valid == $past(acc)) else $error("decode pulse does not follow accept");
  chk_add_flags: assert property (
    acc && insn[13:8] == 6'h07 |=> op_id == `OP_ADD_WREG_FILE && upd_carry && upd_digit_carry
      && upd_zero && !carry_in_used) else $error("add decode wrong");
  chk_logic_zero: assert property (
    acc && insn[13:10] == 4'h1 && insn[9:8] != 2'h3 |=> upd_zero && !upd_carry
      && !upd_digit_carry) else $error("logic op flags wrong");
  chk_rotate_carry: assert property (
    acc && insn[13:9] == 5'h06 |=> upd_carry && carry_in_used && !upd_zero && !upd_digit_carry)
    else $error("rotate flags wrong");
  chk_skip_two: assert property (
    acc && insn[13:8] == 6'h0B && result_zero && insn[6:1] != 6'h00
      |=> skip_next && cycles == 2'h2 ##0 s_one_nop) else $error("skip timing wrong");
  chk_bit_fields: assert property (
    acc && insn[13:12] == 2'h1 |=> bit_idx == $past(insn[9:7]) && file_addr == $past(insn[6:0]))
    else $error("bit op fields wrong");
  chk_literal_byte: assert property (
    acc && insn[13:8] == 6'h3E |=> literal == $past(insn[7:0]) && wr_working && upd_digit_carry)
    else $error("add literal decode wrong");
  chk_pc_latch: assert property (
    acc && insn[13:7] == 7'h63 |=> wr_pc_high_latch && literal == {1'b0, $past(insn[6:0])})
    else $error("pc latch load wrong");
  chk_three_cycles: assert property (
    dec_valid && cycles == 2'h3 |-> s_two_nop) else $error("three cycle spacing wrong");
  chk_indirect_add: assert property (
    acc && insn[13:8] == 6'h07 && insn[6:0] == 7'h01 && fsr1_msb
      |=> indirect_extra && cycles == 2'h2 ##0 s_one_nop) else $error("indirect cycle missing");
  chk_illegal_quiet: assert property (
    acc && insn[13:12] == 2'h2 |=> illegal && op_id == `OP_ILLEGAL && cycles == 2'h1
      && !wr_working && !wr_file) else $error("illegal word not refused");
  chk_ce_hold: assert property (
    !ce |=> $stable(op_id) && $stable(cycles)) else $error("state moved with ce low");
endmodule

bind enhanced_insn_decoder insn_decoder_checker chk_u (
  .clk(clk), .srst(srst), .ce(ce), .insn_valid(insn_valid), .insn(insn),
  .result_zero(result_zero), .tested_bit(tested_bit), .fsr0_msb(fsr0_msb),
  .fsr1_msb(fsr1_msb), .insn_ready(insn_ready), .dec_valid(dec_valid), .op_id(op_id),
  .illegal(illegal), .dest_file(dest_file), .file_addr(file_addr), .bit_idx(bit_idx),
  .literal(literal), .wr_working(wr_working), .wr_file(wr_file),
  .wr_bank_select(wr_bank_select), .wr_pc_high_latch(wr_pc_high_latch),
  .upd_carry(upd_carry), .upd_digit_carry(upd_digit_carry), .upd_zero(upd_zero),
  .carry_in_used(carry_in_used), .skip_next(skip_next), .indirect_extra(indirect_extra),
  .cycles(cycles), .nop_cycle(nop_cycle));

// ---- test/enhanced_insn_decoder_test.sv ----
// Purpose: directed bench for the instruction decoder
// Assumes: inputs change on the falling edge only
// Notes:   word A5h low byte doubles as d=1, address 25h for file ops
`timescale 1ns/1ps
`include "insn_decoder_map.vh"

module enhanced_insn_decoder_test;
  reg        clk = 1'b0;
  reg        srst, ce, insn_valid;
  reg [13:0] insn;
  reg        result_zero, tested_bit, fsr0_msb, fsr1_msb;
  wire       insn_ready, dec_valid, illegal, dest_file, wr_working, wr_file;
  wire       wr_bank_select, wr_pc_high_latch, upd_carry, upd_digit_carry, upd_zero;
  wire       carry_in_used, skip_next, indirect_extra, nop_cycle;
  wire [5:0] op_id;
  wire [6:0] file_addr;
  wire [2:0] bit_idx;
  wire [7:0] literal;
  wire [1:0] cycles;
  integer    err_count = 0;
  integer    compares = 0;

  // Entry: prefix and sub code, operation, carry/digit/zero updates, carry consumed
  localparam [16*25-1:0] DEC_TBL = {
    {6'h3E, `OP_ADD_LITERAL, 4'hE}, {6'h3C, `OP_LIT_MINUS_W, 4'hE},
    {6'h39, `OP_AND_LITERAL, 4'h2}, {6'h38, `OP_OR_LITERAL, 4'h2},
    {6'h3A, `OP_XOR_LITERAL, 4'h2}, {6'h30, `OP_LOAD_WORKING, 4'h0},
    {6'h07, `OP_ADD_WREG_FILE, 4'hE}, {6'h3D, `OP_ADD_CARRY, 4'hF},
    {6'h02, `OP_SUB_WREG, 4'hE}, {6'h3B, `OP_SUB_BORROW, 4'hF},
    {6'h05, `OP_AND_WREG_FILE, 4'h2}, {6'h04, `OP_OR_WREG_FILE, 4'h2},
    {6'h06, `OP_XOR_WREG_FILE, 4'h2}, {6'h37, `OP_ASR_FILE, 4'hA},
    {6'h35, `OP_LSL_FILE, 4'hA}, {6'h36, `OP_LSR_FILE, 4'hA},
    {6'h0D, `OP_ROTATE_LEFT, 4'h9}, {6'h0C, `OP_ROTATE_RIGHT, 4'h9},
    {6'h09, `OP_COMPLEMENT, 4'h2}, {6'h03, `OP_DECREMENT, 4'h2},
    {6'h0A, `OP_INCREMENT, 4'h2}, {6'h08, `OP_MOVE_FILE, 4'h2},
    {6'h0E, `OP_NIBBLE_SWAP, 4'h0}, {6'h01, `OP_CLEAR_FILE, 4'h2},
    {6'h00, `OP_STORE_WORKING, 4'h0}};
  // Entry: word, zero/bit/select0/select1 inputs, extra cycle expected
  localparam [19*5-1:0] IND_TBL = {
    {14'h0781, 4'h1, 1'h1}, {14'h0781, 4'h2, 1'h0}, {14'h0780, 4'h1, 1'h0},
    {14'h3E00, 4'h3, 1'h0}, {14'h1400, 4'h2, 1'h1}};

  enhanced_insn_decoder dut_u (
    .clk(clk), .srst(srst), .ce(ce), .insn_valid(insn_valid), .insn(insn),
    .result_zero(result_zero), .tested_bit(tested_bit), .fsr0_msb(fsr0_msb),
    .fsr1_msb(fsr1_msb), .insn_ready(insn_ready), .dec_valid(dec_valid), .op_id(op_id),
    .illegal(illegal), .dest_file(dest_file), .file_addr(file_addr), .bit_idx(bit_idx),
    .literal(literal), .wr_working(wr_working), .wr_file(wr_file),
    .wr_bank_select(wr_bank_select), .wr_pc_high_latch(wr_pc_high_latch),
    .upd_carry(upd_carry), .upd_digit_carry(upd_digit_carry), .upd_zero(upd_zero),
    .carry_in_used(carry_in_used), .skip_next(skip_next), .indirect_extra(indirect_extra),
    .cycles(cycles), .nop_cycle(nop_cycle));

  always #12.5 clk = ~clk;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t ns: got %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("Summary: %0d mismatches in %0d compares", err_count, compares);
      if (err_count == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // Called at a falling edge; returns at the falling edge after the accept
  task offer(input [13:0] w, input [3:0] side);
    integer n;
    begin
      insn_valid = 1'b1;
      insn = w;
      {result_zero, tested_bit, fsr0_msb, fsr1_msb} = side;
      n = 0;
      while (insn_ready !== 1'b1 && n < 20) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 20) check(1'b0, 1'b1);
      @(posedge clk);
      @(negedge clk);
      check(dec_valid, 1'b1);
    end
  endtask

  task idle;
    begin
      insn_valid = 1'b0;
      @(negedge clk);
    end
  endtask

  // Back-to-back offers: single-cycle ops must not stall the stream
  task t_decode_table;
    integer i;
    reg [15:0] e;
    begin
      for (i = 0; i < 25; i = i + 1) begin
        e = DEC_TBL[i*16 +: 16];
        offer({e[15:10], 8'hA5}, 4'h0);
        check({illegal, op_id}, {1'b0, e[9:4]});
        check({upd_carry, upd_digit_carry, upd_zero, carry_in_used}, e[3:0]);
        check(i >= 19 ? literal : {dest_file, file_addr}, 8'hA5);
        check({wr_working, wr_file}, {i >= 19, i < 19});
      end
      idle;
    end
  endtask

  task t_loads;
    begin
      offer(14'h31AB, 4'h0);
      check({op_id, literal}, {`OP_LOAD_PC_HIGH, 8'h2B});
      check({wr_pc_high_latch, wr_bank_select, wr_working}, 3'h4);
      offer(14'h0035, 4'h0);
      check({op_id, literal}, {`OP_LOAD_BANK, 8'h15});
      check({wr_pc_high_latch, wr_bank_select, wr_working}, 3'h2);
      offer(14'h0103, 4'h0);
      check({op_id, upd_zero, wr_working}, {`OP_CLEAR_WORKING, 2'h3});
      idle;
    end
  endtask

  task t_bit_ops;
    integer i;
    reg skip;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        skip = (i[2:1] == 2'h2 && !i[0]) || (i[2:1] == 2'h3 && i[0]);
        offer({2'h1, i[2:1], 3'h5, 7'h30}, {1'b0, i[0], 2'h0});
        check(op_id, `OP_BIT_CLEAR + i[2:1]);
        check({bit_idx, file_addr}, {3'h5, 7'h30});
        check({skip_next, cycles}, skip ? 3'h6 : 3'h1);
        check({upd_carry, upd_digit_carry, upd_zero}, 3'h0);
      end
      idle;
    end
  endtask

  task t_skips;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        offer({i[1] ? 6'h0F : 6'h0B, 8'hA5}, {i[0], 3'h0});
        check(op_id, i[1] ? `OP_INC_SKIP_ZERO : `OP_DEC_SKIP_ZERO);
        check({skip_next, cycles}, i[0] ? 3'h6 : 3'h1);
        check({upd_carry, upd_digit_carry, upd_zero}, 3'h0);
      end
      offer(14'h0B80, 4'hA);
      check({skip_next, indirect_extra, cycles}, 4'hF);
      idle;
      check({insn_ready, nop_cycle}, 2'h1);
      @(negedge clk);
      check({insn_ready, nop_cycle}, 2'h3);
    end
  endtask

  task t_indirect;
    integer i;
    reg [18:0] e;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        e = IND_TBL[i*19 +: 19];
        offer(e[18:5], e[4:1]);
        check({indirect_extra, cycles}, e[0] ? 3'h6 : 3'h1);
      end
      idle;
    end
  endtask

  // Refused word, a stalled offer with ce low, then a reset in mid-run
  task t_illegal_ce;
    begin
      offer(14'h2123, 4'h0);
      check({op_id, illegal, cycles}, {`OP_ILLEGAL, 3'h5});
      check({wr_working, wr_file, wr_bank_select, wr_pc_high_latch}, 4'h0);
      idle;
      ce = 1'b0;
      insn_valid = 1'b1;
      insn = 14'h0725;
      repeat (3) @(negedge clk);
      check({dec_valid, op_id}, {1'b0, `OP_ILLEGAL});
      ce = 1'b1;
      offer(14'h0725, 4'h0);
      check({op_id, dest_file, wr_working, wr_file}, {`OP_ADD_WREG_FILE, 3'h2});
      idle;
      srst = 1'b1;
      repeat (2) @(negedge clk);
      check({op_id, insn_ready, dec_valid}, {`OP_ILLEGAL, 2'h0});
      srst = 1'b0;
      @(negedge clk);
    end
  endtask

  initial begin
    #(25 * 2000);
    err_count = err_count + 1;
    report_and_stop;
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    insn_valid = 1'b0;
    insn = 14'h0000;
    {result_zero, tested_bit, fsr0_msb, fsr1_msb} = 4'h0;
    repeat (16) @(negedge clk);
    check({op_id, insn_ready}, {`OP_ILLEGAL, 1'b0});
    srst = 1'b0;
    @(negedge clk);
    t_decode_table;
    t_loads;
    t_bit_ops;
    t_skips;
    t_indirect;
    t_illegal_ce;
    t_skips;
    report_and_stop;
  end
endmodule
